// file: verilog/atmr_core.sv
/*
 * advanced timer core: timebase, clock and trigger selection, four
 * capture/compare channels, wishbone classic register slave.
 * assumes asynchronous channel and trigger pins, itrIn on the same clock.
 */
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "atmr_map.svh"
module atmr_core
   import atmr_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int REP_W = 8,
   parameter int FLT_W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // wishbone slave
   input wire atmr_wb_req_t wbReq,
   output logic [31:0] wbDatO,
   output logic wbAck,
   // pins and other timer
   input wire logic [3:0] chPin,
   input wire logic extTrigPin,
   input wire logic itrIn,
   // outputs
   output logic [3:0] chOut,
   output logic [3:0] dmaReq,
   output logic irqReq,
   output logic updateOut
);
   localparam int NCH = 4;

   if (CNT_W < 2 || CNT_W > 16 || REP_W < 1 || REP_W > 16 || FLT_W != 4) begin : g_chk
      $error("atmr_core: unsupported parameter values");
   end

   logic [31:0] ctrl;
   logic [4:0] stat;
   logic [8:0] ien;
   logic [31:0] chCfgW;
   logic [CNT_W-1:0] tickCount;
   logic [CNT_W-1:0] next_tickCount;
   logic [CNT_W-1:0] divPre;
   logic [CNT_W-1:0] divSh;
   logic [CNT_W-1:0] divCnt;
   logic [CNT_W-1:0] reloadPre;
   logic [CNT_W-1:0] reloadSh;
   logic [REP_W-1:0] repPre;
   logic [REP_W-1:0] repTally;
   logic [CNT_W-1:0] match [NCH];
   logic [2:0] capCnt [NCH];
   logic [NCH-1:0] chRef;
   atmr_chcfg_t cfg [NCH];
   atmr_phase_t phase;
   atmr_phase_t next_phase;
   atmr_dir_t dirMode;
   logic [4:0] cLvl;
   logic [4:0] cRise;
   logic [4:0] cFall;
   logic [2:0] etrCnt;
   logic [2:0] etrMask;
   logic etrEdge;
   logic etrPulse;
   logic itrD;
   logic itrRise;
   logic [NCH-1:0] chEdge;
   logic [NCH-1:0] chLvl;
   logic [NCH-1:0] capHit;
   logic [NCH-1:0] cmpHit;
   logic trigPulse;
   logic trigLvl;
   logic srcPulse;
   logic slvRst;
   logic trigStart;
   logic tick;
   logic tickD;
   logic ovf;
   logic unf;
   logic wrapEvt;
   logic swUpd;
   logic forcedUpd;
   logic updEvt;
   logic busSel;
   logic [3:0] ix;
   logic mapped;
   logic [31:0] rdData;
   logic [4:0] statClr;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
      for (int b = 0; b < 4; b++) begin
         merge[b*8 +: 8] = be[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction

   // write strobe for one word; the write lands on the edge that raises ack
   function automatic logic wrHit(input logic [3:0] idx);
      wrHit = busSel && wbReq.we && mapped && (ix == idx);
   endfunction

   assign busSel = wbReq.cyc && wbReq.stb && !wbAck;
   assign ix = wbReq.adr[`ATMR_ADR_IX];
   assign mapped = (wbReq.adr[`ATMR_ADR_HI] == 2'h0) && (ix <= `ATMR_IX_LAST);
   assign dirMode = atmr_dir_t'(ctrl[`ATMR_C_DIR]);

   // input conditioning: channels 0..3, external trigger at 4
   for (genvar i = 0; i < 5; i++) begin : g_in
      atmr_in_cond #(.FLT_W(FLT_W)) u_cond (
         .clk(clk),
         .rst_b(rst_b),
         .pin(i < NCH ? chPin[i % NCH] : extTrigPin),
         .filtLen(ctrl[`ATMR_C_FLT]),
         .level(cLvl[i]),
         .rise(cRise[i]),
         .fall(cFall[i])
      );
   end

   for (genvar i = 0; i < NCH; i++) begin : g_ch
      assign cfg[i] = atmr_chcfg_t'(chCfgW[i*`ATMR_CH_STRIDE +: `ATMR_CH_STRIDE]);
      assign chEdge[i] = cfg[i].pol ? cFall[i] : cRise[i];
      assign chLvl[i] = cLvl[i] ^ cfg[i].pol;
      assign capHit[i] = cfg[i].cap && chEdge[i]
                         && ((capCnt[i] & etrMaskOf(cfg[i].clock_divider)) == etrMaskOf(cfg[i].clock_divider));
      assign cmpHit[i] = !cfg[i].cap && tickD && (tickCount == match[i]);
   end

   function automatic logic [2:0] etrMaskOf(input logic [1:0] clock_divider);
      etrMaskOf = 3'((4'h1 << clock_divider) - 4'h1);
   endfunction

   // external trigger: polarity, division by 1/2/4/8, filter in the conditioner
   assign etrEdge = ctrl[`ATMR_C_EPOL] ? cFall[4] : cRise[4];
   assign etrMask = etrMaskOf(ctrl[`ATMR_C_EPSC]);
   assign etrPulse = etrEdge && ((etrCnt & etrMask) == etrMask);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         etrCnt <= 3'h0;
      end else if (etrEdge) begin
         etrCnt <= etrCnt + 3'h1;
      end
   end

   // other timer's output needs no synchroniser, same clock
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         itrD <= 1'b0;
      end else begin
         itrD <= itrIn;
      end
   end
   assign itrRise = itrIn && !itrD;

   always_comb begin
      trigPulse = 1'b0;
      trigLvl = 1'b0;
      case (ctrl[`ATMR_C_TSEL])
         `ATMR_TS_BOTH: begin
            trigPulse = cRise[0] | cFall[0];
            trigLvl = cLvl[0];
         end
         `ATMR_TS_EXT: begin
            trigPulse = etrPulse;
            trigLvl = cLvl[4] ^ ctrl[`ATMR_C_EPOL];
         end
         `ATMR_TS_ITR: begin
            trigPulse = itrRise;
            trigLvl = itrIn;
         end
         default: begin
            if (ctrl[`ATMR_C_TSEL] < `ATMR_TS_BOTH) begin
               trigPulse = chEdge[2'(ctrl[`ATMR_C_TSEL])];
               trigLvl = chLvl[2'(ctrl[`ATMR_C_TSEL])];
            end
         end
      endcase
   end

   always_comb begin
      case (ctrl[`ATMR_C_SMS])
         `ATMR_SM_EXT1: srcPulse = trigPulse;
         `ATMR_SM_EXT2: srcPulse = etrPulse;
         `ATMR_SM_GATE: srcPulse = trigLvl;
         default: srcPulse = 1'b1;
      endcase
   end
   assign slvRst = (ctrl[`ATMR_C_SMS] == `ATMR_SM_RST) && trigPulse;
   assign trigStart = (ctrl[`ATMR_C_SMS] == `ATMR_SM_TRIG) && trigPulse;

   // divider: ratio divSh+1 covers 1..65536
   assign tick = ctrl[`ATMR_C_EN] && srcPulse && (divCnt == divSh);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         divCnt <= '0;
      end else if (forcedUpd) begin
         divCnt <= '0;
      end else if (ctrl[`ATMR_C_EN] && srcPulse) begin
         divCnt <= (divCnt == divSh) ? '0 : divCnt + 1'b1;
      end
   end

   always_comb begin
      next_tickCount = tickCount;
      next_phase = phase;
      ovf = 1'b0;
      unf = 1'b0;
      case (dirMode)
         ATMR_DOWN: begin
            if (tickCount == '0) begin
               next_tickCount = reloadSh;
               unf = 1'b1;
            end else begin
               next_tickCount = tickCount - 1'b1;
            end
         end
         ATMR_CENTER: begin
            if (phase == ATMR_RISE) begin
               ovf = (tickCount == reloadSh - 1'b1);
               if (tickCount >= reloadSh) begin
                  next_tickCount = tickCount - 1'b1;
                  next_phase = ATMR_FALL;
               end else begin
                  next_tickCount = tickCount + 1'b1;
               end
            end else begin
               unf = (tickCount == CNT_W'(1));
               if (tickCount == '0) begin
                  next_tickCount = tickCount + 1'b1;
                  next_phase = ATMR_RISE;
               end else begin
                  next_tickCount = tickCount - 1'b1;
               end
            end
         end
         default: begin
            if (tickCount >= reloadSh) begin
               next_tickCount = '0;
               ovf = 1'b1;
            end else begin
               next_tickCount = tickCount + 1'b1;
            end
         end
      endcase
   end

   assign wrapEvt = tick && (ovf || unf);
   assign swUpd = wrHit(`ATMR_IX_CTRL) && wbReq.sel[2] && wbReq.dat[`ATMR_C_UG];
   assign forcedUpd = swUpd || slvRst;
   assign updEvt = (wrapEvt && repTally == '0 && !ctrl[`ATMR_C_UINH]) || forcedUpd;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tickCount <= '0;
         phase <= ATMR_RISE;
      end else if (wrHit(`ATMR_IX_CNT)) begin
         tickCount <= CNT_W'(merge(32'(tickCount), wbReq.dat, wbReq.sel));
      end else if (forcedUpd) begin
         tickCount <= (dirMode == ATMR_DOWN) ? reloadPre : '0;
         phase <= ATMR_RISE;
      end else if (tick) begin
         tickCount <= next_tickCount;
         phase <= next_phase;
      end
   end

   // repeat tally counts wraps down to zero, then reloads
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         repTally <= '0;
      end else if (forcedUpd || (wrapEvt && repTally == '0)) begin
         repTally <= repPre;
      end else if (wrapEvt) begin
         repTally <= repTally - 1'b1;
      end
   end

   // shadows move only on an update so a running period is never torn
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reloadSh <= CNT_W'(`ATMR_RST_RLD);
         divSh <= '0;
      end else if (updEvt) begin
         reloadSh <= reloadPre;
         divSh <= divPre;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tickD <= 1'b0;
         updateOut <= 1'b0;
      end else begin
         tickD <= tick;
         updateOut <= updEvt;
      end
   end

   // configuration words
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= `ATMR_RST_WORD;
      end else if (wrHit(`ATMR_IX_CTRL)) begin
         ctrl <= merge(ctrl, wbReq.dat, wbReq.sel) & ~(32'h1 << `ATMR_C_UG);
      end else if (trigStart) begin
         ctrl[`ATMR_C_EN] <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ien <= '0;
         chCfgW <= `ATMR_RST_WORD;
         divPre <= '0;
         reloadPre <= CNT_W'(`ATMR_RST_RLD);
         repPre <= '0;
      end else begin
         if (wrHit(`ATMR_IX_IEN)) begin
            ien <= 9'(merge(32'(ien), wbReq.dat, wbReq.sel));
         end
         if (wrHit(`ATMR_IX_CHCF)) begin
            chCfgW <= merge(chCfgW, wbReq.dat, wbReq.sel);
         end
         if (wrHit(`ATMR_IX_DIV)) begin
            divPre <= CNT_W'(merge(32'(divPre), wbReq.dat, wbReq.sel));
         end
         if (wrHit(`ATMR_IX_RLD)) begin
            reloadPre <= CNT_W'(merge(32'(reloadPre), wbReq.dat, wbReq.sel));
         end
         if (wrHit(`ATMR_IX_REP)) begin
            repPre <= REP_W'(merge(32'(repPre), wbReq.dat, wbReq.sel));
         end
      end
   end

   // status: write one to clear, a new event in the same cycle wins
   assign statClr = wrHit(`ATMR_IX_STAT) && wbReq.sel[0] ? wbReq.dat[`ATMR_S_ALL] : 5'h0;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stat <= 5'h0;
      end else begin
         stat <= (stat & ~statClr) | {capHit | cmpHit, updEvt};
      end
   end

   // channel match values: bus writes, captures latch the count
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NCH; i++) begin
            match[i] <= '0;
            capCnt[i] <= 3'h0;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (capHit[i]) begin
               match[i] <= tickCount;
            end else if (wrHit(4'(`ATMR_IX_CH0 + i))) begin
               match[i] <= CNT_W'(merge(32'(match[i]), wbReq.dat, wbReq.sel));
            end
            if (cfg[i].cap && chEdge[i]) begin
               capCnt[i] <= capCnt[i] + 3'h1;
            end
         end
      end
   end

   // reference level per compare output mode
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chRef <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (!cfg[i].cap) begin
               unique case (cfg[i].mode)
                  `ATMR_OC_FRZ: chRef[i] <= chRef[i];
                  `ATMR_OC_ACT: chRef[i] <= chRef[i] | cmpHit[i];
                  `ATMR_OC_INACT: chRef[i] <= chRef[i] & ~cmpHit[i];
                  `ATMR_OC_TOG: chRef[i] <= chRef[i] ^ cmpHit[i];
                  `ATMR_OC_LO: chRef[i] <= 1'b0;
                  `ATMR_OC_HI: chRef[i] <= 1'b1;
                  `ATMR_OC_PWM1: chRef[i] <= (tickCount < match[i]);
                  `ATMR_OC_PWM2: chRef[i] <= (tickCount >= match[i]);
               endcase
            end
         end
      end
   end

   // polarity applied last; adds one flop so the pin is glitch-free
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chOut <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            chOut[i] <= chRef[i] ^ cfg[i].pol;
         end
      end
   end

   assign irqReq = |(stat & ien[`ATMR_S_ALL]);
   assign dmaReq = stat[`ATMR_S_CH] & ien[`ATMR_E_DMA];

   always_comb begin
      rdData = `ATMR_RST_WORD;
      if (mapped) begin
         case (ix)
            `ATMR_IX_CTRL: rdData = ctrl;
            `ATMR_IX_STAT: rdData = 32'(stat);
            `ATMR_IX_IEN: rdData = 32'(ien);
            `ATMR_IX_CNT: rdData = 32'(tickCount);
            `ATMR_IX_DIV: rdData = 32'(divPre);
            `ATMR_IX_RLD: rdData = 32'(reloadPre);
            `ATMR_IX_REP: rdData = 32'(repPre);
            `ATMR_IX_CHCF: rdData = chCfgW;
            default: rdData = 32'(match[ix[1:0]]);
         endcase
      end
   end

   // single-cycle ack; unmapped reads return zero, writes are dropped
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wbAck <= 1'b0;
         wbDatO <= `ATMR_RST_WORD;
      end else begin
         wbAck <= busSel;
         if (busSel) begin
            wbDatO <= rdData;
         end
      end
   end
endmodule
`default_nettype wire

// file: verilog/atmr_map.svh
/*
 * register map, field positions, reset values and mode codes of the
 * advanced timer core. assumes wishbone byte addresses, one 32-bit word each.
 */
`ifndef ATMR_MAP_SVH
`define ATMR_MAP_SVH
// address decode: word index and bits that must be zero
`define ATMR_ADR_IX 5:2
`define ATMR_ADR_HI 7:6
// word indexes
`define ATMR_IX_CTRL 4'h0
`define ATMR_IX_STAT 4'h1
`define ATMR_IX_IEN 4'h2
`define ATMR_IX_CNT 4'h3
`define ATMR_IX_DIV 4'h4
`define ATMR_IX_RLD 4'h5
`define ATMR_IX_REP 4'h6
`define ATMR_IX_CHCF 4'h7
`define ATMR_IX_CH0 4'h8
`define ATMR_IX_LAST 4'hb
// control word fields
`define ATMR_C_EN 0
`define ATMR_C_DIR 2:1
`define ATMR_C_UINH 3
`define ATMR_C_SMS 6:4
`define ATMR_C_TSEL 9:7
`define ATMR_C_EPOL 10
`define ATMR_C_EPSC 12:11
`define ATMR_C_FLT 16:13
`define ATMR_C_UG 17
// status and enable fields
`define ATMR_S_UPD 0
`define ATMR_S_CH 4:1
`define ATMR_S_ALL 4:0
`define ATMR_E_DMA 8:5
`define ATMR_CH_STRIDE 8
// reset values
`define ATMR_RST_WORD 32'h0000_0000
`define ATMR_RST_RLD 16'hffff
// slave modes
`define ATMR_SM_INT 3'h0
`define ATMR_SM_EXT1 3'h1
`define ATMR_SM_EXT2 3'h2
`define ATMR_SM_RST 3'h3
`define ATMR_SM_GATE 3'h4
`define ATMR_SM_TRIG 3'h5
// trigger selects, 0 to 3 are the filtered channel inputs
`define ATMR_TS_BOTH 3'h4
`define ATMR_TS_EXT 3'h5
`define ATMR_TS_ITR 3'h6
// compare output modes
`define ATMR_OC_FRZ 3'h0
`define ATMR_OC_ACT 3'h1
`define ATMR_OC_INACT 3'h2
`define ATMR_OC_TOG 3'h3
`define ATMR_OC_LO 3'h4
`define ATMR_OC_HI 3'h5
`define ATMR_OC_PWM1 3'h6
`define ATMR_OC_PWM2 3'h7
`endif

// file: verilog/atmr_pkg.sv
/*
 * types of the advanced timer core.
 * assumes atmr_map.svh for numeric constants.
 */
package atmr_pkg;
   typedef enum logic [1:0] {
      ATMR_UP = 2'h0,
      ATMR_DOWN = 2'h1,
      ATMR_CENTER = 2'h2
   } atmr_dir_t;
   typedef enum logic [1:0] {
      ATMR_RISE = 2'b01,
      ATMR_FALL = 2'b10
   } atmr_phase_t;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } atmr_wb_req_t;
   typedef struct packed {
      logic spare;
      logic [1:0] clock_divider;
      logic pol;
      logic cap;
      logic [2:0] mode;
   } atmr_chcfg_t;
endpackage

// file: verilog/atmr_in_cond.sv
/*
 * input conditioner: two-stage synchroniser, stability filter, edge pulses.
 * assumes an asynchronous pin and the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module atmr_in_cond #(
   parameter int FLT_W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // pin and filter length
   input wire logic pin,
   input wire logic [FLT_W-1:0] filtLen,
   // conditioned signal
   output logic level,
   output logic rise,
   output logic fall
);
   logic s1;
   logic s2;
   logic [FLT_W-1:0] stable;
   logic accept;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
      end
   end

   // a change is taken only after it held for filtLen+1 samples
   assign accept = (s2 != level) && (stable >= filtLen);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stable <= '0;
      end else if (s2 == level || accept) begin
         stable <= '0;
      end else begin
         stable <= stable + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level <= 1'b0;
         rise <= 1'b0;
         fall <= 1'b0;
      end else begin
         if (accept) begin
            level <= s2;
         end
         rise <= accept & s2;
         fall <= accept & ~s2;
      end
   end
endmodule
`default_nettype wire

// file: bench/atmr_core_assertions.sv
/*
 * checker for the advanced timer core, bound to atmr_core.
 * assumes full-word bus writes (sel 4'hf) and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module atmr_core_checker
   import atmr_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int REP_W = 8,
   parameter int FLT_W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // bus
   input wire atmr_wb_req_t wbReq,
   input wire logic [31:0] wbDatO,
   input wire logic wbAck,
   // pins
   input wire logic [3:0] chPin,
   input wire logic extTrigPin,
   input wire logic itrIn,
   // outputs
   input wire logic [3:0] chOut,
   input wire logic [3:0] dmaReq,
   input wire logic irqReq,
   input wire logic updateOut
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic take;
   logic [31:0] ctrlS;
   logic [31:0] ienS;
   logic [31:0] cfgS;
   logic [2:0] quiet;
   assign take = wbReq.cyc && wbReq.stb && !wbAck;
   // copies land at the same edge as the slave's write; partial sel not modelled
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrlS <= 32'h0;
         ienS <= 32'h0;
         cfgS <= 32'h0;
      end else if (take && wbReq.we) begin
         if (wbReq.adr == 8'h00) ctrlS <= wbReq.dat;
         if (wbReq.adr == 8'h08) ienS <= wbReq.dat;
         if (wbReq.adr == 8'h1c) cfgS <= wbReq.dat;
      end
   end
   // cycles since the last write, so pending updates have drained
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) quiet <= 3'h0;
      else if (take && wbReq.we) quiet <= 3'h0;
      else if (quiet != 3'h7) quiet <= quiet + 3'h1;
   end
   sequence s_forced;
      cfgS[18:17] == 2'b10 && !cfgS[19];
   endsequence
   property p_ackNext; take |=> wbAck; endproperty
   a_ackNext: assert property (p_ackNext) else $error("request not acked next cycle");
   property p_ackPulse; wbAck |=> !wbAck; endproperty
   a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
   property p_noAck; !(wbReq.cyc && wbReq.stb) |=> !wbAck; endproperty
   a_noAck: assert property (p_noAck) else $error("ack without request");
   property p_unmapped;
      wbAck && !$past(wbReq.we) && ($past(wbReq.adr) > 8'h2f) |-> wbDatO == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_dmaSel; (dmaReq & ~ienS[8:5]) == 4'h0; endproperty
   a_dmaSel: assert property (p_dmaSel) else $error("dma without select");
   property p_irqSel; irqReq |-> ienS[4:0] != 5'h0; endproperty
   a_irqSel: assert property (p_irqSel) else $error("irq without enable");
   property p_force; s_forced [*4] |-> chOut[2] == (cfgS[16] ^ cfgS[20]); endproperty
   a_force: assert property (p_force) else $error("forced level wrong");
   property p_inhibit;
      ctrlS[3] && ctrlS[6:4] == 3'h0 && quiet == 3'h7 |-> !updateOut;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("update while inhibited");
   property p_rstQuiet;
      $rose(rst_b) |-> chOut == 4'h0 && dmaReq == 4'h0 && !irqReq && !updateOut && !wbAck;
   endproperty
   a_rstQuiet: assert property (p_rstQuiet) else $error("outputs active after reset");
endmodule
bind atmr_core atmr_core_checker #(.CNT_W(CNT_W), .REP_W(REP_W), .FLT_W(FLT_W)) chk_i (
   .clk(clk), .rst_b(rst_b), .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck),
   .chPin(chPin), .extTrigPin(extTrigPin), .itrIn(itrIn), .chOut(chOut),
   .dmaReq(dmaReq), .irqReq(irqReq), .updateOut(updateOut));
`default_nettype wire

// file: bench/tb.sv
/*
 * self-checking bench for the advanced timer core.
 * assumes the 1-cycle wishbone answer and register map of the core.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import atmr_pkg::*;
   logic clk = 1'b0;
   logic rst_b;
   atmr_wb_req_t wbReq;
   logic [31:0] wbDatO, q, c1;
   logic wbAck, extTrigPin, itrIn, irqReq, updateOut;
   logic [3:0] chPin, chOut, dmaReq;
   int err_count = 0;
   int checked = 0;
   int seed = 29;
   int d, r, n, c, m, k, ts;
   int hi [4];
   // control words: ext pin, itr, channel 0 edge, both edges, ext clock 2, gated
   int tsl [6] = '{32'h20291, 32'h20311, 32'h20011, 32'h20211, 32'h20c21, 32'h20041};
   int tex [6] = '{6, 6, 6, 12, 3, 24};
   always #5 clk = ~clk;
   atmr_core dut (.clk(clk), .rst_b(rst_b), .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck),
      .chPin(chPin), .extTrigPin(extTrigPin), .itrIn(itrIn), .chOut(chOut),
      .dmaReq(dmaReq), .irqReq(irqReq), .updateOut(updateOut));
   task automatic wrap_up;
      if (err_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // request held until ack is seen, then released for one cycle
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat,
      output logic [31:0] rd);
      wbReq <= '{1'b1, 1'b1, we, a, 4'hf, dat};
      // no limit here: a slave that never answers is caught by the watchdog
      do begin
         @(posedge clk);
      end while (wbAck !== 1'b1);
      rd = wbDatO;
      wbReq <= '0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      wb(1'b1, a, dat, q);
   endtask
   // spacing in cycles between two update pulses
   task automatic gap(output int cnt);
      int t;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (updateOut !== 1'b1 && t < 3000);
      cnt = 0;
      do begin
         @(posedge clk);
         cnt++;
      end while (updateOut !== 1'b1 && cnt < 3000);
   endtask
   // high cycles per output over four periods of ten, after two to settle
   task automatic sample_hi;
      repeat (20) @(posedge clk);
      foreach (hi[j]) hi[j] = 0;
      repeat (40) begin
         @(posedge clk);
         foreach (hi[j]) hi[j] += chOut[j];
      end
   endtask
   // center mode wraps twice per sweep, so each event is r ticks apart
   function automatic int period(int dir, int rl, int dv, int rp);
      return (rp + 1) * (dv + 1) * ((dir == 2) ? rl : rl + 1);
   endfunction
   initial begin
      #400000;
      err_count++;
      wrap_up();
   end
   initial begin
      rst_b = 1'b0;
      wbReq = '0;
      chPin = 4'h0;
      extTrigPin = 1'b0;
      itrIn = 1'b0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      wb(1'b0, 8'h14, 32'h0, q);
      chk(q, 32'h0000ffff);
      wr(8'h40, 32'h1234);
      wb(1'b0, 8'h40, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b0, 8'h30, 32'h0, q);
      chk(q, 32'h0);
      for (int i = 0; i < 6; i++) begin
         d = $random(seed) & 3;
         r = 2 + ($random(seed) & 7);
         n = ($random(seed) & 3) % 3;
         wr(8'h10, d);
         wr(8'h14, r);
         wr(8'h18, n);
         wr(8'h00, 32'h20001 | ((i % 3) << 1));
         gap(c);
         gap(c);
         chk(c, period(i % 3, r, d, n));
      end
      m = 1 + ($random(seed) & 7);
      wr(8'h14, 32'h9);
      wr(8'h10, 32'h0);
      wr(8'h18, 32'h0);
      wr(8'h20, m);
      wr(8'h24, m);
      wr(8'h1c, 32'h14050706);
      wr(8'h08, 32'h22);
      wr(8'h00, 32'h20001);
      sample_hi();
      chk(hi[0], 4 * m);
      chk(hi[1], 40 - 4 * m);
      chk(hi[2], 40);
      chk(hi[3], 40);
      chk(irqReq, 32'h1);
      chk(dmaReq, 32'h1);
      wr(8'h1c, 32'h03050201);
      sample_hi();
      chk(hi[0], 40);
      chk(hi[1], 0);
      chk(hi[3], 20);
      wr(8'h00, 32'h9);
      repeat (3) @(posedge clk);
      c = 0;
      repeat (60) begin
         @(posedge clk);
         c += updateOut;
      end
      chk(c, 0);
      wr(8'h00, 32'h0);
      repeat (4) @(posedge clk);
      wr(8'h04, 32'h1f);
      chk(irqReq, 32'h0);
      chk(dmaReq, 32'h0);
      wr(8'h08, 32'h0);
      k = 30 + ($random(seed) & 15);
      wr(8'h1c, 32'h08);
      wr(8'h14, 32'hffff);
      wr(8'h00, 32'h20001);
      chPin <= 4'h1;
      repeat (10) @(posedge clk);
      wb(1'b0, 8'h20, 32'h0, c1);
      chPin <= 4'h0;
      repeat (k - 13) @(posedge clk);
      chPin <= 4'h1;
      repeat (10) @(posedge clk);
      wb(1'b0, 8'h20, 32'h0, q);
      chk(q - c1, k);
      wb(1'b0, 8'h04, 32'h0, q);
      chk(q & 32'h2, 32'h2);
      chPin <= 4'h0;
      for (int i = 0; i < 6; i++) begin
         ts = (tsl[i] >> 7) & 7;
         n = (tsl[i] >> 4) & 7;
         wr(8'h00, tsl[i]);
         repeat (6) begin
            if (ts == 5 || n == 2) extTrigPin <= 1'b1;
            else if (ts == 6) itrIn <= 1'b1;
            else chPin <= 4'h1;
            repeat (4) @(posedge clk);
            extTrigPin <= 1'b0;
            itrIn <= 1'b0;
            chPin <= 4'h0;
            repeat (4) @(posedge clk);
         end
         repeat (8) @(posedge clk);
         wb(1'b0, 8'h0c, 32'h0, q);
         chk(q, tex[i]);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
